/* File: logic/ocd_pkg.sv */
// Purpose: shared constants and types for the option byte configuration decoder
// Assumes: 32-bit apb data, 12-bit byte address, one word per register
// Notes: option byte field positions, defaults and register offsets live here only
package ocd_pkg;

  // register byte offsets on the programming-side apb port
  localparam logic [11:0] ADDR_OPT0 = 12'h000;
  localparam logic [11:0] ADDR_OPT1 = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;

  // unprogrammed content of a configuration byte
  localparam logic [7:0] OPT_DEFAULT = 8'hff;

  // byte 0 field positions
  localparam int B0_HALT = 7;
  localparam int B0_WDSW = 6;
  localparam int B0_CLOCK_SOURCE_SELECT = 5;
  localparam int B0_VD_HI = 4;
  localparam int B0_VD_LO = 3;
  localparam int B0_RESET_CYCLE_SELECT = 2;
  localparam int B0_OSCILLATOR_HALVING = 1;
  localparam int B0_RDP = 0;

  // byte 1 field positions
  localparam int B1_PKG_HI = 7;
  localparam int B1_PKG_LO = 5;
  localparam int B1_MOT_HI = 1;
  localparam int B1_MOT_LO = 0;

  // control and status bit positions
  localparam int CTRL_ERASE = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PROG = 1;
  localparam int STAT_MEMER = 2;
  localparam int STAT_LAT0_LO = 8;
  localparam int STAT_LAT1_LO = 16;

  // voltage detector codes
  localparam logic [1:0] VD_BOTH = 2'h0;
  localparam logic [1:0] VD_RESET_ONLY = 2'h1;

  // reset and halt-exit phase lengths in cpu cycles
  localparam int CYC_W = 13;
  localparam logic [12:0] CYC_LONG = 13'h1000;
  localparam logic [12:0] CYC_SHORT = 13'h0100;

  // package codes, top bit set means the largest package
  localparam logic [2:0] PKG_80 = 3'h4;

  // motor output reset-state codes
  localparam logic [1:0] MOT_LOW = 2'h1;
  localparam logic [1:0] MOT_HIGH = 2'h2;

  // decoded reset values, equal to the decode of two unprogrammed bytes
  localparam logic [2:0] PKG_RESET = 3'h4;

  // controller states, one-hot
  typedef enum logic [3:0] {
    ST_LOAD = 4'h1,
    ST_RUN = 4'h2,
    ST_MEMER = 4'h4,
    ST_OPTER = 4'h8
  } ocd_fsm_type;

endpackage

/* File: logic/ocd_nv_store.sv */
// Purpose: holds the two non-volatile configuration bytes
// Assumes: por_n models loss of nothing but power; only programming logic drives it
// Notes: content survives presetn; a blank store reads as all ones
`timescale 1ns/1ps
module ocd_nv_store import ocd_pkg::*; (
  // clock and power-on reset
  input wire logic pclk,
  input wire logic por_n,
  // programming write port
  input wire logic wr_en,
  input wire logic wr_index,
  input wire logic [7:0] wr_data,
  input wire logic erase,
  // stored content
  output logic [7:0] byte0,
  output logic [7:0] byte1
);

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
  } ocd_store_type;

  ocd_store_type st_r;
  ocd_store_type st_nxt;

  // erase wins over a write in the same cycle, it is the later step of a sequence
  always_comb begin
    st_nxt = st_r;
    if (wr_en && !wr_index) begin
      st_nxt.b0 = wr_data;
    end
    if (wr_en && wr_index) begin
      st_nxt.b1 = wr_data;
    end
    if (erase) begin
      st_nxt.b0 = OPT_DEFAULT;
      st_nxt.b1 = OPT_DEFAULT;
    end
  end

  // blank bytes read as all ones
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      st_r <= {OPT_DEFAULT, OPT_DEFAULT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign byte0 = st_r.b0;
  assign byte1 = st_r.b1;

endmodule

/* File: logic/ocd_config_decode.sv */
// Purpose: option byte loader, decoder and programming-mode access port
// Assumes: apb master is the programming tool; mode pins are asynchronous
// Notes: settings load once after reset release and hold until the next reset
`timescale 1ns/1ps
module ocd_config_decode import ocd_pkg::*; (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic prog_mode_pin,
  input wire logic test_mode_pin,
  input wire logic icp_mode_pin,
  // user memory erase handshake
  output logic user_mem_erase_req,
  input wire logic user_mem_erase_done,
  // decoded options
  output logic halt_reset_on_watchdog,
  output logic watchdog_soft_enable,
  output logic clock_source_select,
  output logic low_voltage_reset_detector_en,
  output logic auxiliary_voltage_detector_en,
  output logic [12:0] reset_cycle_count,
  output logic oscillator_halving,
  output logic readout_protect,
  output logic prog_mem_block,
  output logic [2:0] package_select,
  output logic motor_output_reset_oe,
  output logic motor_output_reset_level
);

  typedef struct packed {
    ocd_fsm_type fsm;
    logic prog_s1;
    logic prog_s2;
    logic test_s1;
    logic test_s2;
    logic icp_s1;
    logic icp_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wr_ok;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane;
    logic mem_erase_req;
    logic [7:0] lat0;
    logic [7:0] lat1;
    logic halt_rst;
    logic wd_soft;
    logic clk_src;
    logic lvr_en;
    logic avd_en;
    logic [12:0] rst_cycles;
    logic osc_halving;
    logic rdp_en;
    logic pm_block;
    logic [2:0] pkg;
    logic mot_oe;
    logic mot_level;
  } ocd_regs_type;

  ocd_regs_type st_r;
  ocd_regs_type st_nxt;

  logic [7:0] store_b0;
  logic [7:0] store_b1;
  logic store_wr;
  logic store_idx;
  logic store_erase;
  logic setup;
  logic access;
  logic mapped;
  logic ok;

  // phase length: the pll source overrides the short setting
  function automatic logic [12:0] cycles_of(input logic [7:0] b0);
    if (!b0[B0_CLOCK_SOURCE_SELECT]) begin
      return CYC_LONG;
    end
    return b0[B0_RESET_CYCLE_SELECT] ? CYC_SHORT : CYC_LONG;
  endfunction

  // any code with the top bit set means the largest package
  function automatic logic [2:0] pkg_of(input logic [7:0] b1);
    logic [2:0] code;
    code = b1[B1_PKG_HI:B1_PKG_LO];
    return code[2] ? PKG_80 : code;
  endfunction

  // non-volatile bytes, kept across presetn
  ocd_nv_store u_store (
    .pclk(pclk),
    .por_n(por_n),
    .wr_en(store_wr),
    .wr_index(store_idx),
    .wr_data(st_r.wr_data),
    .erase(store_erase),
    .byte0(store_b0),
    .byte1(store_b1)
  );

  // apb phase decode; the answer is prepared in setup so outputs stay registered
  assign setup = psel && !penable;
  assign access = psel && penable && st_r.pready;
  assign mapped = (paddr == ADDR_OPT0) || (paddr == ADDR_OPT1) ||
                  (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
  assign ok = st_r.prog_s2 && mapped && (!pwrite || st_r.fsm == ST_RUN);

  // store writes land at the access edge only, low byte lane required
  assign store_wr = access && st_r.wr_ok && st_r.wr_lane &&
                    (st_r.wr_addr == ADDR_OPT0 || st_r.wr_addr == ADDR_OPT1);
  assign store_idx = (st_r.wr_addr == ADDR_OPT1);
  // option erase after memory erase on a protected part, at once otherwise
  assign store_erase = (st_r.fsm == ST_OPTER);

  // next state of every register in the block
  always_comb begin
    st_nxt = st_r;
    // pins pass two flops before anything reads them
    st_nxt.prog_s1 = prog_mode_pin;
    st_nxt.prog_s2 = st_r.prog_s1;
    st_nxt.test_s1 = test_mode_pin;
    st_nxt.test_s2 = st_r.test_s1;
    st_nxt.icp_s1 = icp_mode_pin;
    st_nxt.icp_s2 = st_r.icp_s1;

    // apb answer built in setup, released after the access edge
    if (setup) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !ok;
      st_nxt.wr_ok = ok && pwrite;
      st_nxt.wr_addr = paddr;
      st_nxt.wr_data = pwdata[7:0];
      st_nxt.wr_lane = pstrb[0];
      st_nxt.prdata = 32'h0;
      if (ok && !pwrite) begin
        case (paddr)
          ADDR_OPT0: st_nxt.prdata[7:0] = store_b0;
          ADDR_OPT1: st_nxt.prdata[7:0] = store_b1;
          ADDR_STAT: begin
            st_nxt.prdata[STAT_BUSY] = (st_r.fsm != ST_RUN);
            st_nxt.prdata[STAT_PROG] = st_r.prog_s2;
            st_nxt.prdata[STAT_MEMER] = st_r.mem_erase_req;
            st_nxt.prdata[STAT_LAT0_LO +: 8] = st_r.lat0;
            st_nxt.prdata[STAT_LAT1_LO +: 8] = st_r.lat1;
          end
          default: st_nxt.prdata = 32'h0;
        endcase
      end
    end else if (access) begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.wr_ok = 1'b0;
    end

    case (st_r.fsm)
      ST_LOAD: begin
        st_nxt.lat0 = store_b0;
        st_nxt.lat1 = store_b1;
        st_nxt.halt_rst = store_b0[B0_HALT];
        st_nxt.wd_soft = store_b0[B0_WDSW];
        st_nxt.clk_src = store_b0[B0_CLOCK_SOURCE_SELECT];
        // detector enables, code 3 read as both off
        st_nxt.lvr_en = (store_b0[B0_VD_HI:B0_VD_LO] == VD_BOTH) ||
                        (store_b0[B0_VD_HI:B0_VD_LO] == VD_RESET_ONLY);
        st_nxt.avd_en = (store_b0[B0_VD_HI:B0_VD_LO] == VD_BOTH);
        st_nxt.rst_cycles = cycles_of(store_b0);
        // divider active when bit is zero
        st_nxt.osc_halving = !store_b0[B0_OSCILLATOR_HALVING];
        st_nxt.rdp_en = !store_b0[B0_RDP];
        st_nxt.pkg = pkg_of(store_b1);
        // motor output reset state; reserved bits 4:2 are never read
        st_nxt.mot_oe = (store_b1[B1_MOT_HI:B1_MOT_LO] == MOT_LOW) ||
                        (store_b1[B1_MOT_HI:B1_MOT_LO] == MOT_HIGH);
        st_nxt.mot_level = (store_b1[B1_MOT_HI:B1_MOT_LO] == MOT_HIGH);
        st_nxt.fsm = ST_RUN;
      end
      ST_RUN: begin
        if (access && st_r.wr_ok && st_r.wr_lane && st_r.wr_addr == ADDR_CTRL &&
            st_r.wr_data[CTRL_ERASE]) begin
          if (!store_b0[B0_RDP]) begin
            st_nxt.fsm = ST_MEMER;
            st_nxt.mem_erase_req = 1'b1;
          end else begin
            st_nxt.fsm = ST_OPTER;
          end
        end
      end
      ST_MEMER: begin
        // request held until the memory reports it is blank
        if (user_mem_erase_done) begin
          st_nxt.mem_erase_req = 1'b0;
          st_nxt.fsm = ST_OPTER;
        end
      end
      ST_OPTER: begin
        st_nxt.fsm = ST_RUN;
      end
      default: begin
        st_nxt.fsm = ST_RUN;
        st_nxt.mem_erase_req = 1'b0;
      end
    endcase

    // block program memory in test and icp modes on a protected part
    st_nxt.pm_block = st_r.rdp_en && (st_r.test_s2 || st_r.icp_s2);
  end

  // reset values are the decode of blank bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{fsm: ST_LOAD, prdata: 32'h0, wr_addr: 12'h000, wr_data: 8'h00,
                lat0: OPT_DEFAULT, lat1: OPT_DEFAULT, halt_rst: 1'b1, wd_soft: 1'b1,
                clk_src: 1'b1, rst_cycles: CYC_SHORT, pkg: PKG_RESET, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign user_mem_erase_req = st_r.mem_erase_req;
  assign halt_reset_on_watchdog = st_r.halt_rst;
  assign watchdog_soft_enable = st_r.wd_soft;
  assign clock_source_select = st_r.clk_src;
  assign low_voltage_reset_detector_en = st_r.lvr_en;
  assign auxiliary_voltage_detector_en = st_r.avd_en;
  assign reset_cycle_count = st_r.rst_cycles;
  assign oscillator_halving = st_r.osc_halving;
  assign readout_protect = st_r.rdp_en;
  assign prog_mem_block = st_r.pm_block;
  assign package_select = st_r.pkg;
  assign motor_output_reset_oe = st_r.mot_oe;
  assign motor_output_reset_level = st_r.mot_level;

  property p_gate_prog;
    @(posedge pclk) disable iff (!presetn)
    setup && !st_r.prog_s2 |=> pready && pslverr && prdata == 32'h0;
  endproperty
  a_gate_prog: assert property (p_gate_prog) else $error("access outside prog mode");

  property p_erase_ones;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm == ST_OPTER |=> store_b0 == OPT_DEFAULT && store_b1 == OPT_DEFAULT;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase not all ones");

  // halt reset follows the captured bit; the release edge itself still shows reset
  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    presetn && st_r.fsm == ST_LOAD |=> halt_reset_on_watchdog == $past(store_b0[B0_HALT]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt reset option wrong");

  // watchdog soft enable is off when the captured bit is clear
  property p_wdsw;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm == ST_LOAD ##1 !st_r.lat0[B0_WDSW] |-> !watchdog_soft_enable;
  endproperty
  a_wdsw: assert property (p_wdsw) else $error("watchdog type wrong");

  // clock source matches the latched byte
  property p_clock_source_select;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD |-> clock_source_select == st_r.lat0[B0_CLOCK_SOURCE_SELECT];
  endproperty
  a_clock_source_select: assert property (p_clock_source_select) else $error("clock source wrong");

  // code zero turns on both detectors
  property p_vd;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD && st_r.lat0[B0_VD_HI:B0_VD_LO] == VD_BOTH |->
      low_voltage_reset_detector_en && auxiliary_voltage_detector_en;
  endproperty
  a_vd: assert property (p_vd) else $error("detector enables wrong");

  // oscillator clock with bit set gives the short phase
  property p_short;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD && st_r.lat0[B0_CLOCK_SOURCE_SELECT] && st_r.lat0[B0_RESET_CYCLE_SELECT] |->
      reset_cycle_count == CYC_SHORT;
  endproperty
  a_short: assert property (p_short) else $error("short phase wrong");

  // pll source always gives the long phase
  property p_pll_long;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD && !clock_source_select |-> reset_cycle_count == CYC_LONG;
  endproperty
  a_pll_long: assert property (p_pll_long) else $error("pll phase not long");

  // divider active exactly when the bit is zero
  property p_div;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD |-> oscillator_halving != st_r.lat0[B0_OSCILLATOR_HALVING];
  endproperty
  a_div: assert property (p_div) else $error("divider wrong");

  // protected part blocks memory one cycle after a test or icp mode
  property p_block;
    @(posedge pclk) disable iff (!presetn)
    readout_protect && (st_r.test_s2 || st_r.icp_s2) |=> prog_mem_block;
  endproperty
  a_block: assert property (p_block) else $error("memory not blocked");

  // option bytes untouched while memory erase is pending
  property p_mem_first;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm == ST_MEMER && !user_mem_erase_done |=>
      st_r.fsm == ST_MEMER && user_mem_erase_req && !store_erase;
  endproperty
  a_mem_first: assert property (p_mem_first) else $error("options erased first");

  // top package bit selects the largest package
  property p_pkg;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD && st_r.lat1[B1_PKG_HI] |-> package_select == PKG_80;
  endproperty
  a_pkg: assert property (p_pkg) else $error("package decode wrong");

  // code one drives low under reset
  property p_motor;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD && st_r.lat1[B1_MOT_HI:B1_MOT_LO] == MOT_LOW |->
      motor_output_reset_oe && !motor_output_reset_level;
  endproperty
  a_motor: assert property (p_motor) else $error("motor reset state wrong");

  // latched settings never move after loading
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st_r.fsm != ST_LOAD |=> $stable(st_r.lat0) && $stable(st_r.lat1) &&
      $stable(reset_cycle_count);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed after load");

endmodule

/* File: dv/ocd_prog_tool.sv */
// Purpose: programming tool model driving the decoder's apb port
// Assumes: one transfer at a time, signals change just after a rising edge
// Notes: the request is held until pready is seen high at a rising edge or 50 edges pass
`timescale 1ns/1ps
module ocd_prog_tool (
  // clock
  input wire logic pclk,
  // apb master side
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // programming mode entry
  output logic prog_mode_pin
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    prog_mode_pin = 1'b1;
  end

  // leave or enter programming mode after an edge
  task automatic set_mode(input logic m);
    @(posedge pclk);
    prog_mode_pin <= m;
  endtask

  // one transfer; address and write data are inverted on release so stale values never match
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic tout);
    int n;
    n = 0;
    tout = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tout = (n >= 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= 4'h0;
  endtask
endmodule

/* File: dv/test_option_byte_config_decode.sv */
// Purpose: self-checking bench for the option byte configuration decoder
// Assumes: tool model drives apb; bench drives resets, mode pins, erase answer
// Notes: a behavioural decode model is compared with the outputs after each load
`timescale 1ns/1ps
module test_option_byte_config_decode import ocd_pkg::*; ;
  logic pclk;
  logic presetn;
  logic por_n;
  logic test_mode_pin;
  logic icp_mode_pin;
  logic user_mem_erase_done;
  logic user_mem_erase_req;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [3:0] pstrb;
  logic psel, penable, pwrite, pready, pslverr, prog_mode_pin;
  logic halt, wdsw, cksrc, lvr, auxiliary_voltage_detector, halving, protect, block, mot_oe, mot_lvl;
  logic [12:0] cycles;
  logic [2:0] pkg;
  logic [24:0] dec;
  bit req_seen;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] l0;
  logic [7:0] l1;
  logic [31:0] rd;
  logic err;
  logic memer;
  int fails;
  int total_checks;
  int cnt;
  int dly;

  ocd_config_decode dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_mode_pin(prog_mode_pin),
    .test_mode_pin(test_mode_pin), .icp_mode_pin(icp_mode_pin),
    .user_mem_erase_req(user_mem_erase_req), .user_mem_erase_done(user_mem_erase_done),
    .halt_reset_on_watchdog(halt), .watchdog_soft_enable(wdsw), .clock_source_select(cksrc),
    .low_voltage_reset_detector_en(lvr), .auxiliary_voltage_detector_en(auxiliary_voltage_detector),
    .reset_cycle_count(cycles), .oscillator_halving(halving), .readout_protect(protect),
    .prog_mem_block(block), .package_select(pkg), .motor_output_reset_oe(mot_oe),
    .motor_output_reset_level(mot_lvl));

  ocd_prog_tool tool (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_mode_pin(prog_mode_pin));

  // decoded outputs in one 25-bit word, halt dropped off the top; level only matters while driven
  assign dec = {halt, wdsw, cksrc, lvr, auxiliary_voltage_detector, cycles, halving, protect, block, pkg,
                mot_oe, mot_oe & mot_lvl};

  always #2 pclk = ~pclk;

  // memory side answers an erase request after a variable delay
  always @(posedge pclk) begin
    if (user_mem_erase_req === 1'b1) begin
      cnt <= cnt + 1;
      req_seen <= 1'b1;
    end else begin
      cnt <= 0;
    end
    user_mem_erase_done <= (user_mem_erase_req === 1'b1) && (cnt == dly);
  end

  // expected decode of two option bytes; pin is test or icp mode
  function automatic logic [24:0] model(input logic [7:0] b0, input logic [7:0] b1,
                                        input logic pin);
    logic [12:0] cyc;
    logic [2:0] pk;
    cyc = (!b0[5] || !b0[2]) ? 13'h1000 : 13'h0100;
    pk = b1[7] ? 3'h4 : b1[7:5];
    return {b0[7], b0[6], b0[5], !b0[4], b0[4:3] == 2'h0, cyc, !b0[1], !b0[0],
            !b0[0] & pin, pk, ^b1[1:0], b1[1:0] == 2'h2};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    logic t;
    tool.xfer(w, a, d, rd, err, t);
    if (t !== 1'b0) begin
      fails++;
      $display("Error at %0t: bus answer never came", $time);
      report_and_stop();
    end
  endtask

  // compare every decoded output but halt, which falls off the top of the 25-bit word, with the model
  task automatic chk_dec(input logic [7:0] e0, input logic [7:0] e1, input logic pin,
                         input string what);
    chk({7'h00, dec}, {7'h00, model(e0, e1, pin)}, what);
  endtask

  // mid-run reset; the store keeps its bytes while outputs show the blank decode
  task automatic pulse_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_dec(OPT_DEFAULT, OPT_DEFAULT, 1'b0, "decode during reset");
    @(posedge pclk);
    presetn <= 1'b1;
    // sync flops restart low, so prog mode needs two edges before any setup
    repeat (3) @(posedge pclk);
  endtask

  // poll status until the erase sequence is over; a stuck busy bit ends the run
  task automatic wait_idle(output logic seen);
    logic [31:0] sr;
    logic se;
    int n;
    n = 0;
    seen = 1'b0;
    do begin
      bus(1'b0, ADDR_STAT, 32'h0, sr, se);
      seen = seen | sr[STAT_MEMER];
      n++;
    end while (sr[STAT_BUSY] !== 1'b0 && n < 40);
    if (sr[STAT_BUSY] !== 1'b0) begin
      fails++;
      $display("Error at %0t: erase sequence never finished", $time);
      report_and_stop();
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    por_n = 1'b0;
    test_mode_pin = 1'b0;
    icp_mode_pin = 1'b0;
    fails = 0;
    total_checks = 0;
    void'($urandom(59));
    // at least four cycles of memory erase so the busy window can be probed
    dly = 4 + int'($urandom % 32'd4);
    l0 = OPT_DEFAULT;
    l1 = OPT_DEFAULT;
    repeat (2) @(posedge pclk);
    chk_dec(OPT_DEFAULT, OPT_DEFAULT, 1'b0, "decode in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_dec(OPT_DEFAULT, OPT_DEFAULT, 1'b0, "blank decode");
    bus(1'b0, ADDR_OPT0, 32'h0, rd, err);
    chk({31'h0, err}, 32'h0, "blank read error");
    chk(rd, {24'h0, OPT_DEFAULT}, "blank byte0");
    // each pass forces the fields whose codes need covering, the rest is random
    for (int i = 0; i < 8; i++) begin
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      b0[5:3] = 3'(i);
      b0[2] = i[1];
      b0[0] = i[2];
      b1[1:0] = 2'(i);
      b1[7] = i[0];
      bus(1'b1, ADDR_OPT0, {24'h0, b0}, rd, err);
      bus(1'b1, ADDR_OPT1, {24'h0, b1}, rd, err);
      bus(1'b0, ADDR_OPT0, 32'h0, rd, err);
      chk(rd, {24'h0, b0}, "byte0 readback");
      bus(1'b0, ADDR_OPT1, 32'h0, rd, err);
      chk(rd, {24'h0, b1}, "byte1 readback");
      chk_dec(l0, l1, 1'b0, "held decode");
      pulse_reset();
      chk_dec(b0, b1, 1'b0, "loaded decode");
      l0 = b0;
      l1 = b1;
      bus(1'b0, ADDR_STAT, 32'h0, rd, err);
      chk(rd, {8'h00, b1, b0, 8'h02}, "latched status");
      // a test or icp mode pin blocks memory only on a protected part
      test_mode_pin <= i[0];
      icp_mode_pin <= !i[0];
      repeat (5) @(posedge pclk);
      chk_dec(b0, b1, 1'b1, "mode pin block");
      test_mode_pin <= 1'b0;
      icp_mode_pin <= 1'b0;
    end
    // outside programming mode every access is refused and nothing lands
    tool.set_mode(1'b0);
    repeat (3) @(posedge pclk);
    bus(1'b1, ADDR_OPT0, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "write outside prog mode");
    bus(1'b0, ADDR_OPT1, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "read outside prog mode");
    chk(rd, 32'h0, "data outside prog mode");
    tool.set_mode(1'b1);
    repeat (3) @(posedge pclk);
    bus(1'b0, 12'h010, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped read");
    bus(1'b0, ADDR_OPT0, 32'h0, rd, err);
    chk(rd, {24'h0, l0}, "byte0 untouched");
    // unprotected erase clears the options without touching user memory
    b0 = 8'($urandom) | 8'h01;
    bus(1'b1, ADDR_OPT0, {24'h0, b0}, rd, err);
    bus(1'b1, ADDR_OPT1, 32'h0, rd, err);
    bus(1'b1, ADDR_CTRL, 32'h1, rd, err);
    wait_idle(memer);
    chk({30'h0, memer, req_seen}, 32'h0, "unprotected erase hit memory");
    bus(1'b0, ADDR_OPT0, 32'h0, rd, err);
    chk(rd, {24'h0, OPT_DEFAULT}, "erased byte0");
    bus(1'b0, ADDR_OPT1, 32'h0, rd, err);
    chk(rd, {24'h0, OPT_DEFAULT}, "erased byte1");
    // protected erase goes through user memory first and refuses writes meanwhile
    b0 = 8'($urandom) & 8'hfe;
    bus(1'b1, ADDR_OPT0, {24'h0, b0}, rd, err);
    bus(1'b1, ADDR_CTRL, 32'h1, rd, err);
    bus(1'b1, ADDR_OPT1, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "write while busy");
    wait_idle(memer);
    chk({30'h0, memer, req_seen}, 32'h3, "protected erase skipped memory");
    bus(1'b0, ADDR_OPT0, 32'h0, rd, err);
    chk(rd, {24'h0, OPT_DEFAULT}, "protected erased byte0");
    bus(1'b0, ADDR_OPT1, 32'h0, rd, err);
    chk(rd, {24'h0, OPT_DEFAULT}, "protected erased byte1");
    chk_dec(l0, l1, 1'b0, "held through erase");
    pulse_reset();
    chk_dec(OPT_DEFAULT, OPT_DEFAULT, 1'b0, "blank after erase");
    report_and_stop();
  end
endmodule
